// ==== logic/ppw_consts.svh ====
// Offsets, field positions, reset values and timing counts of the power management block
`ifndef PPW_CONSTS_SVH
`define PPW_CONSTS_SVH
`define PPW_ADR_CFG 4'h0
`define PPW_ADR_STAT 4'h1
`define PPW_ADR_AUX 4'h2
`define PPW_ADR_INTR 4'h3
`define PPW_ADR_ENA 4'h4
`define PPW_ADR_IDENT 4'h5
`define PPW_ADR_CMN 4'h6
`define PPW_ADR_MODE 4'h7
`define PPW_CFG_WAKE_OUTPUT_DISABLE 0
`define PPW_CFG_WAKE_OUTPUT_POLARITY 1
`define PPW_CFG_WAKE_OE 2
`define PPW_CFG_BEACON_DIS 3
`define PPW_INT_PM 0
`define PPW_INT_LEGACY 1
`define PPW_INT_MSI 2
`define PPW_INT_W 3
`define PPW_CFG_RST 4'h0
`define PPW_AUX_FORCE 2'h3
`define PPW_PME_HOLD_NS 100
`define PPW_CLK_MHZ 200
`endif

// ==== logic/ppw_pkg.sv ====
// Types shared by the power management block
package ppw_pkg;
	typedef enum logic [1:0] {
		PPW_D0,
		PPW_D1,
		PPW_D2,
		PPW_D3
	} ppw_dstate_t;
	typedef enum logic [1:0] {
		PPW_W_IDLE,
		PPW_W_PME,
		PPW_W_HOLD
	} ppw_wst_t;
endpackage

// ==== logic/ppw_sync.sv ====
// Two flip-flop synchroniser for pin level inputs
`timescale 1ns/1ps
module ppw_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ppw_sync_st_t;
	ppw_sync_st_t st;
	ppw_sync_st_t next_st;
	always_comb begin
		next_st.s1 = d_i;
		next_st.s2 = st.s1;
		if (rst_i) begin
			next_st = '0;
		end
	end
	always_ff @(posedge clk_i) begin
		st <= next_st;
	end
	assign q_o = st.s2;
endmodule // ppw_sync

// ==== logic/ppw_wake.sv ====
// Wake pin driver: polarity, drive scheme and disable
`timescale 1ns/1ps
`include "ppw_consts.svh"
module ppw_wake (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_i,
	input wire logic dis_i,
	input wire logic pol_i,
	input wire logic oe_mode_i,
	output logic wake_out_o,
	output logic wake_oe_o
);
	typedef struct packed {
		logic out;
		logic oe;
	} ppw_wake_st_t;
	ppw_wake_st_t st;
	ppw_wake_st_t next_st;
	logic act;
	always_comb begin
		act = req_i & ~dis_i;
		next_st.out = act ? pol_i : ~pol_i;
		// Open-drain style drives only while asserting; push-pull drives always
		next_st.oe = oe_mode_i ? 1'b1 : act;
		if (rst_i) begin
			next_st.out = 1'b0;
			next_st.oe = 1'b0;
		end
	end
	always_ff @(posedge clk_i) begin
		st <= next_st;
	end
	assign wake_out_o = st.out;
	assign wake_oe_o = st.oe;
endmodule // ppw_wake

// ==== logic/ppw_top.sv ====
// Power management, wake and interrupt reception around the PCIe controller
// Functional notes
// - RC legacy interrupt raises CPU interrupt line
// - RC MSI message triggers write to programmed address
// - Support D0, D1 and D3 power states
// - State changes never alter switch core automatically
// - Aux config 3 advertises PME from D3cold
// - Readable power state; change sets sticky bit
// - Enable gates interrupt; identify nonzero means active
// - PME only with PME enable and power-down
// - Outbound bus or DMA request triggers PME
// - Enabled interrupt change triggers PME unless disabled
// - D3 sends beacon, or wake pin when beacon disabled
// - Wake disable, polarity and drive configurable
`timescale 1ns/1ps
`include "ppw_consts.svh"
module ppw_top
	import ppw_pkg::*;
#(
	parameter int AW = 32
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rc_mode_i,
	input wire logic [1:0] current_power_state_field_i,
	input wire logic pme_en_i,
	input wire logic legacy_irq_rx_i,
	input wire logic msi_rx_i,
	input wire logic [AW-1:0] msi_addr_i,
	input wire logic [31:0] msi_data_i,
	output logic msi_wr_o,
	output logic [AW-1:0] msi_wr_addr_o,
	output logic [31:0] msi_wr_data_o,
	input wire logic msi_wr_done_i,
	input wire logic system_bus_master_req_i,
	input wire logic dma_req_i,
	input wire logic [2:0] out_irq_i,
	input wire logic [2:0] out_irq_ena_i,
	output logic pme_o,
	output logic aux_pme_d3cold_o,
	output logic beacon_o,
	output logic wake_out_o,
	output logic wake_oe_o,
	output logic irq_o
);
	localparam int HOLD_CYC = (`PPW_PME_HOLD_NS * `PPW_CLK_MHZ + 999) / 1000;
	localparam logic [7:0] HOLD_LAST = 8'(HOLD_CYC - 1);
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [3:0] cfg;
		logic [1:0] aux;
		logic [`PPW_INT_W-1:0] sticky;
		logic [`PPW_INT_W-1:0] ena;
		logic pme_on_irq_change_disable;
		logic [1:0] current_power_state_field;
		logic [2:0] irq_prev;
		logic req_prev;
		logic legacy_prev;
		logic msi_prev;
		logic msi_wr;
		logic [AW-1:0] msi_wr_addr;
		logic [31:0] msi_wr_data;
		ppw_wst_t wst;
		logic [7:0] hold;
	} ppw_st_t;
	ppw_st_t st;
	ppw_st_t next_st;
	logic [1:0] pm_sync;
	logic legacy_sync;
	logic wake_req;
	logic in_d3;
	logic power_down;
	logic pme_trig;
	logic [`PPW_INT_W-1:0] set_ev;
	logic [`PPW_INT_W-1:0] clr_ev;
	logic [`PPW_INT_W-1:0] pcie_active_irq_sources;
	logic wr_hit;
	logic [3:0] word;
	logic [7:0] lane;
	logic req_any;

	// Apply byte enables to the low byte of a register
	function automatic logic [7:0] ppw_lane0(
		input logic [7:0] old,
		input logic [31:0] d,
		input logic [3:0] sel
	);
		ppw_lane0 = sel[0] ? d[7:0] : old;
	endfunction

	// Level seen now but not in the previous cycle
	function automatic logic ppw_rise(
		input logic now,
		input logic prev
	);
		ppw_rise = now & ~prev;
	endfunction

	// State and legacy level come from the controller's own clock

	ppw_sync #(.W(2)) u_pm_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(current_power_state_field_i),
		.q_o(pm_sync)
	);
	ppw_sync #(.W(1)) u_leg_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(legacy_irq_rx_i),
		.q_o(legacy_sync)
	);

	always_comb begin
		word = wb_adr_i[5:2];
		wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & ~st.ack;
		lane = 8'h0;
		req_any = system_bus_master_req_i | dma_req_i;
		in_d3 = st.current_power_state_field == 2'(PPW_D3);
		power_down = st.current_power_state_field != 2'(PPW_D0);
		set_ev = '0;
		set_ev[`PPW_INT_PM] = pm_sync != st.current_power_state_field;
		set_ev[`PPW_INT_LEGACY] = rc_mode_i & ppw_rise(legacy_sync, st.legacy_prev);
		set_ev[`PPW_INT_MSI] = rc_mode_i & ppw_rise(msi_rx_i, st.msi_prev);
		clr_ev = '0;
		if (wr_hit && word == `PPW_ADR_INTR && wb_sel_i[0]) begin
			clr_ev = wb_dat_i[`PPW_INT_W-1:0];
		end
		pcie_active_irq_sources = st.sticky & st.ena;
		// Edge based triggers, so a request held high asks for one PME only
		pme_trig = ppw_rise(req_any, st.req_prev)
			| ((|((out_irq_i ^ st.irq_prev) & out_irq_ena_i))
			& ~st.pme_on_irq_change_disable);
		next_st = st;
		next_st.ack = wb_cyc_i & wb_stb_i & ~st.ack;
		next_st.rdata = '0;
		if (wb_cyc_i && wb_stb_i && !wb_we_i && !st.ack) begin
			case (word)
				`PPW_ADR_CFG: next_st.rdata[3:0] = st.cfg;
				`PPW_ADR_STAT: next_st.rdata[1:0] = st.current_power_state_field;
				`PPW_ADR_AUX: next_st.rdata[1:0] = st.aux;
				`PPW_ADR_INTR: next_st.rdata[`PPW_INT_W-1:0] = st.sticky;
				`PPW_ADR_ENA: next_st.rdata[`PPW_INT_W-1:0] = st.ena;
				`PPW_ADR_IDENT: next_st.rdata[`PPW_INT_W-1:0] = pcie_active_irq_sources;
				`PPW_ADR_CMN: next_st.rdata[0] = st.pme_on_irq_change_disable;
				`PPW_ADR_MODE: next_st.rdata[0] = rc_mode_i;
				default: next_st.rdata = '0;
			endcase
		end
		if (wr_hit) begin
			case (word)
				`PPW_ADR_CFG: begin
					lane = ppw_lane0({4'h0, st.cfg}, wb_dat_i, wb_sel_i);
					next_st.cfg = lane[3:0];
				end
				`PPW_ADR_AUX: begin
					lane = ppw_lane0({6'h0, st.aux}, wb_dat_i, wb_sel_i);
					next_st.aux = lane[1:0];
				end
				`PPW_ADR_ENA: begin
					lane = ppw_lane0({5'h0, st.ena}, wb_dat_i, wb_sel_i);
					next_st.ena = lane[`PPW_INT_W-1:0];
				end
				`PPW_ADR_CMN: begin
					lane = ppw_lane0({7'h0, st.pme_on_irq_change_disable}, wb_dat_i, wb_sel_i);
					next_st.pme_on_irq_change_disable = lane[0];
				end
				default: next_st.cfg = st.cfg;
			endcase
		end
		// Set wins over a write-one clear in the same cycle
		next_st.sticky = (st.sticky & ~clr_ev) | set_ev;
		next_st.current_power_state_field = pm_sync;
		next_st.irq_prev = out_irq_i;
		next_st.req_prev = req_any;
		next_st.legacy_prev = legacy_sync;
		next_st.msi_prev = msi_rx_i;
		// Forward a received MSI as a memory write to its programmed address
		// A new message while the write is still pending is dropped
		if (rc_mode_i && ppw_rise(msi_rx_i, st.msi_prev) && !st.msi_wr) begin
			next_st.msi_wr = 1'b1;
			next_st.msi_wr_addr = msi_addr_i;
			next_st.msi_wr_data = msi_data_i;
		end else if (st.msi_wr && msi_wr_done_i) begin
			next_st.msi_wr = 1'b0;
		end
		case (st.wst)
			PPW_W_IDLE: begin
				if (!rc_mode_i && pme_en_i && power_down && pme_trig) begin
					next_st.wst = PPW_W_PME;
				end
			end
			// Hold keeps a burst of triggers from flooding the link with PMEs
			PPW_W_PME: begin
				next_st.wst = PPW_W_HOLD;
				next_st.hold = HOLD_LAST;
			end
			PPW_W_HOLD: begin
				if (st.hold == 8'h0) begin
					next_st.wst = PPW_W_IDLE;
				end else begin
					next_st.hold = st.hold - 8'h1;
				end
			end
			default: next_st.wst = PPW_W_IDLE;
		endcase
		if (rst_i) begin
			next_st = '0;
			next_st.cfg = `PPW_CFG_RST;
			next_st.wst = PPW_W_IDLE;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	// Wake request stands while a PME is sent and through its hold time, in D3 with beacon disabled
	assign wake_req = (st.wst != PPW_W_IDLE) & in_d3 & st.cfg[`PPW_CFG_BEACON_DIS];

	ppw_wake u_wake (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.req_i(wake_req),
		.dis_i(st.cfg[`PPW_CFG_WAKE_OUTPUT_DISABLE]),
		.pol_i(st.cfg[`PPW_CFG_WAKE_OUTPUT_POLARITY]),
		.oe_mode_i(st.cfg[`PPW_CFG_WAKE_OE]),
		.wake_out_o(wake_out_o),
		.wake_oe_o(wake_oe_o)
	);

	assign wb_ack_o = st.ack;
	assign wb_dat_o = st.rdata;
	assign msi_wr_o = st.msi_wr;
	assign msi_wr_addr_o = st.msi_wr_addr;
	assign msi_wr_data_o = st.msi_wr_data;
	assign pme_o = st.wst == PPW_W_PME;
	assign aux_pme_d3cold_o = ~rc_mode_i & (st.aux == `PPW_AUX_FORCE);
	assign beacon_o = in_d3 & ~rc_mode_i & ~st.cfg[`PPW_CFG_BEACON_DIS];
	// Only an interrupt; switch core is not touched by state changes
	assign irq_o = |pcie_active_irq_sources;
endmodule // ppw_top

// ==== dv/ppw_far.sv ====
// Far-side completer of the interrupt memory writes
`timescale 1ns/1ps
module ppw_far (
	input wire logic clk_i,
	input wire logic wr_i,
	input wire logic [3:0] lat_i,
	output logic done_o
);
	logic [3:0] wait_cnt = 4'h0;
	// Completes each write lat_i+1 cycles after it starts, with a one cycle done
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		wait_cnt <= 4'h0;
		if (wr_i && !done_o) begin
			wait_cnt <= wait_cnt + 4'h1;
			done_o <= wait_cnt == lat_i;
		end
	end
endmodule // ppw_far

// ==== dv/ppw_chk_assertions.sv ====
// Port assertions of the power management block
`timescale 1ns/1ps
module ppw_chk #(
	parameter int AW = 32
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic rc_mode_i,
	input wire logic pme_en_i,
	input wire logic msi_rx_i,
	input wire logic [AW-1:0] msi_addr_i,
	input wire logic msi_wr_o,
	input wire logic [AW-1:0] msi_wr_addr_o,
	input wire logic msi_wr_done_i,
	input wire logic pme_o,
	input wire logic aux_pme_d3cold_o,
	input wire logic beacon_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence msi_go;
		rc_mode_i && $rose(msi_rx_i) && !msi_wr_o;
	endsequence
	ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack long");
	msi_start_a: assert property (msi_go |=> msi_wr_o && msi_wr_addr_o == $past(msi_addr_i))
		else $error("msi write missing");
	msi_hold_a: assert property (msi_wr_o && !msi_wr_done_i |=> msi_wr_o)
		else $error("msi write dropped");
	msi_end_a: assert property (msi_wr_o && msi_wr_done_i |=> !msi_wr_o)
		else $error("msi write stuck");
	pme_cond_a: assert property (pme_o |-> $past(pme_en_i) && !$past(rc_mode_i))
		else $error("pme not allowed");
	pme_one_a: assert property (pme_o |=> !pme_o)
		else $error("pme too long");
	aux_rc_a: assert property (rc_mode_i && $past(rc_mode_i) |-> !aux_pme_d3cold_o)
		else $error("aux in rc");
	beacon_rc_a: assert property (rc_mode_i && $past(rc_mode_i) |-> !beacon_o)
		else $error("beacon in rc");
endmodule // ppw_chk
bind ppw_top ppw_chk #(.AW(AW)) u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.rc_mode_i, .pme_en_i, .msi_rx_i, .msi_addr_i, .msi_wr_o, .msi_wr_addr_o,
	.msi_wr_done_i, .pme_o, .aux_pme_d3cold_o, .beacon_o);

// ==== dv/pcie_power_mgmt_wake_tb.sv ====
// Self-checking bench of the power management block
`timescale 1ns/1ps
module pcie_power_mgmt_wake_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, we = 1'b0, rc = 1'b0, pen = 1'b0, leg = 1'b0, msi = 1'b0;
	logic sbm = 1'b0, dma = 1'b0;
	logic [5:0] adr = 6'h0;
	logic [31:0] dat = 32'h0, rd;
	logic [1:0] pst = 2'h0;
	logic [2:0] oi = 3'h0, oe = 3'h7;
	logic [3:0] lat = 4'h0;
	logic [7:0] np;
	logic [31:0] ma_exp = 32'h8000_0040, md_exp = 32'h0000_00a5;
	logic [19:0] rows [9] = '{20'h00f0f, 20'h1ff00, 20'h2ff03, 20'h3ff00, 20'h4ff07,
		20'h5ff00, 20'h6ff01, 20'h7ff00, 20'h9ff00};
	logic [7:0] wk [4] = '{8'ha3, 8'h81, 8'hb0, 8'hf1};
	logic [3:0] lt [2] = '{4'h0, 4'h6};
	wire logic [31:0] dato, ma, md;
	wire logic ack, mwr, done, pme, aux, bcn, wko, wkoe, irq;
	int failures = 0, compares = 0;
	ppw_top uut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack),
		.rc_mode_i(rc), .current_power_state_field_i(pst), .pme_en_i(pen), .legacy_irq_rx_i(leg),
		.msi_rx_i(msi), .msi_addr_i(ma_exp), .msi_data_i(md_exp), .msi_wr_o(mwr),
		.msi_wr_addr_o(ma), .msi_wr_data_o(md), .msi_wr_done_i(done),
		.system_bus_master_req_i(sbm), .dma_req_i(dma), .out_irq_i(oi), .out_irq_ena_i(oe),
		.pme_o(pme), .aux_pme_d3cold_o(aux), .beacon_o(bcn), .wake_out_o(wko),
		.wake_oe_o(wkoe), .irq_o(irq));
	ppw_far far (.clk_i, .wr_i(mwr), .lat_i(lat), .done_o(done));
	task chk(string n, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task wb(logic w, logic [3:0] a, logic [31:0] d);
		cyc <= 1'b1;
		we <= w;
		adr <= {a, 2'b00};
		dat <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		rd = dato;
		cyc <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask
	// Counts pme pulses over n cycles
	task cnt(int n);
		np = 8'h0;
		repeat (n) begin
			@(posedge clk_i);
			np += {7'h0, pme};
		end
	endtask
	task stop_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial forever #2.5 clk_i = ~clk_i;
	initial begin
		#20us;
		failures++;
		stop_test;
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[i]) begin
			wb(1'b0, rows[i][19:16], 32'h0);
			chk("reset value", 0, rd);
			wb(1'b1, rows[i][19:16], {24'h0, rows[i][15:8]});
			wb(1'b0, rows[i][19:16], 32'h0);
			chk("register", {24'h0, rows[i][7:0]}, rd);
		end
		chk("aux", 1, aux);
		rc <= 1'b1;
		cnt(2);
		chk("aux rc", 0, aux);
		rc <= 1'b0;
		wb(1'b1, 4'h6, 0);
		wb(1'b1, 4'h0, 0);
		$display("registers done");
		pst <= 2'h3;
		cnt(6);
		chk("irq", 1, irq);
		wb(1'b0, 4'h1, 0);
		chk("state", 3, rd);
		wb(1'b0, 4'h5, 0);
		chk("ident", 1, rd);
		wb(1'b1, 4'h3, 1);
		chk("irq clear", 0, irq);
		wb(1'b1, 4'h4, 6);
		pst <= 2'h1;
		cnt(6);
		wb(1'b0, 4'h3, 0);
		chk("masked", 1, rd);
		chk("irq masked", 0, irq);
		wb(1'b0, 4'h1, 0);
		chk("state d1", 1, rd);
		$display("power state done");
		pen <= 1'b1;
		dma <= 1'b1;
		cnt(30);
		chk("pme dma", 1, np);
		dma <= 1'b0;
		cnt(2);
		sbm <= 1'b1;
		cnt(30);
		chk("pme bus", 1, np);
		sbm <= 1'b0;
		oi <= 3'h2;
		cnt(30);
		chk("pme irq", 1, np);
		wb(1'b1, 4'h6, 1);
		oi <= 3'h0;
		cnt(30);
		chk("pme off", 0, np);
		wb(1'b1, 4'h6, 0);
		pen <= 1'b0;
		dma <= 1'b1;
		cnt(30);
		chk("pme disabled", 0, np);
		dma <= 1'b0;
		pen <= 1'b1;
		pst <= 2'h0;
		cnt(6);
		dma <= 1'b1;
		cnt(30);
		chk("pme d0", 0, np);
		dma <= 1'b0;
		pst <= 2'h3;
		cnt(6);
		chk("beacon", 1, bcn);
		foreach (wk[i]) begin
			wb(1'b1, 4'h0, {28'h0, wk[i][7:4]});
			dma <= 1'b1;
			cnt(6);
			chk("wake", wk[i][1:0], {wko, wkoe});
			dma <= 1'b0;
			cnt(30);
		end
		chk("no beacon", 0, bcn);
		$display("pme and wake done");
		rc <= 1'b1;
		wb(1'b1, 4'h4, 7);
		wb(1'b1, 4'h3, 7);
		leg <= 1'b1;
		cnt(6);
		chk("legacy irq", 1, irq);
		wb(1'b0, 4'h3, 0);
		chk("legacy bit", 2, rd);
		foreach (lt[i]) begin
			lat <= lt[i];
			msi <= 1'b1;
			cnt(2);
			msi <= 1'b0;
			chk("msi write", 1, mwr);
			chk("msi address", ma_exp, ma);
			chk("msi data", md_exp, md);
			cnt(12);
			chk("msi end", 0, mwr);
		end
		wb(1'b0, 4'h3, 32'h0);
		chk("msi bit", 6, rd);
		$display("root complex done");
		rst_i <= 1'b1;
		cnt(3);
		chk("irq reset", 0, irq);
		chk("wake reset", 0, {wko, wkoe});
		chk("msi reset", 0, mwr);
		rst_i <= 1'b0;
		wb(1'b0, 4'h4, 32'h0);
		chk("enable reset", 0, rd);
		wb(1'b0, 4'h0, 32'h0);
		chk("config reset", 0, rd);
		$display("reset done");
		stop_test;
	end
endmodule // pcie_power_mgmt_wake_tb
